// >>> hpu_pkg.sv
package hpu_pkg;

  // Interface select pin codes (hi, mid, lo); hi low means serial
  localparam logic [2:0] IF_PAR8  = 3'h4;
  localparam logic [2:0] IF_PAR16 = 3'h5;
  localparam logic [2:0] IF_PAR9  = 3'h6;
  localparam logic [2:0] IF_PAR18 = 3'h7;

  // Command bytes the unpacker reacts to
  localparam logic [7:0] PIXEL_FORMAT_COMMAND = 8'h3a;
  localparam logic [7:0] RAM_WRITE_COMMAND    = 8'h2c;

  // Low three bits of the pixel-format parameter
  localparam logic [2:0] FMT_12BPP = 3'h3;
  localparam logic [2:0] FMT_16BPP = 3'h5;
  localparam logic [2:0] FMT_18BPP = 3'h6;

  typedef enum logic [1:0] {
    HPU_D12 = 2'h0,
    HPU_D16 = 2'h1,
    HPU_D18 = 2'h2
  } hpu_depth_t;

  typedef enum logic [1:0] {
    HPU_BK8  = 2'h0,
    HPU_BK9  = 2'h1,
    HPU_BK16 = 2'h2,
    HPU_BK18 = 2'h3
  } hpu_bus_t;

  localparam hpu_depth_t DEPTH_RESET = HPU_D18;

  localparam int BUS_W = 18;

  // Serial bits per byte frame
  localparam logic [3:0] SER_BITS_3LINE = 4'h9;
  localparam logic [3:0] SER_BITS_4LINE = 4'h8;

  // Register map, 8-bit data, word index addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam int         REG_LUT_SEL_BIT  = 7;
  localparam logic [6:0] LUT_GREEN_BASE   = 7'h20;
  localparam logic [6:0] LUT_BLUE_BASE    = 7'h60;
  localparam int         LUT_ENTRIES      = 128;
  localparam int         CTRL_LUT_EN_BIT  = 0;
  localparam logic       CTRL_LUT_EN_RESET = 1'b0;
  localparam int         STAT_DEPTH_LSB   = 0;
  localparam int         STAT_IF_LSB      = 2;
  localparam int         STAT_FMT_PEND_BIT = 5;
  localparam int         STAT_RAMWR_BIT   = 6;
  localparam int         STAT_SERIAL_BIT  = 7;

endpackage : hpu_pkg

// >>> hpu_unpacker.sv
//
// Contract
// - Select code 100: 8-bit parallel bus, depths 4-4-4, 5-6-5, 6-6-6.
// - Select code 101: 16-bit parallel bus, depths 4-4-4, 5-6-5, 6-6-6.
// - Select code 110: 9-bit parallel bus, 6-6-6 depth only.
// - Select code 111: 18-bit parallel bus, depths 4-4-4, 5-6-5, 6-6-6.
// - Format parameter 03h, 05h, 06h selects 12, 16, 18 bits per pixel.
// - 8-bit bus, 12-bit depth: three bytes carry two pixels, D7 first, 4-bit components.
// - 8-bit bus, 16-bit depth: two bytes form one 5-6-5 pixel.
// - In 5-6-5 green is 6 bits, red and blue 5 bits.
// - 8-bit bus, 18-bit depth: three bytes, one 6-bit component each.
// - Unused bus bits are ignored; host may drive either level.
// - 16-bit bus, 12-bit depth: one transfer on D11 to D0.
// - 16-bit bus, 16-bit depth: one 5-6-5 transfer on D15 to D0.
// - 16-bit bus, 18-bit depth: three transfers carry two pixels.
// - 9-bit bus uses D8 to D0 with 6-bit components.
// - 18-bit bus: one transfer per pixel in every depth.
// - 3-line and 4-line serial carry all depths, MSB first.
// - Serial 12-bit: each component sent bit 3 down to 0.
// - Data flag high means data or parameter, low means command.
// - Write only complete pixels; drop any trailing partial pixel.
// - Every pixel stored as 6-6-6, write issued when complete.
`timescale 1ns/1ns
module hpu_unpacker (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic                      bus_select_pin_hi,
  input  wire logic                      bus_select_pin_mid,
  input  wire logic                      bus_select_pin_lo,
  input  wire logic                      four_wire_sel,
  input  wire logic                      chip_select_n,
  input  wire logic                      write_strobe_n,
  input  wire logic                      data_command_flag,
  input  wire logic [hpu_pkg::BUS_W-1:0] bus_data,
  input  wire logic                      serial_clock,
  input  wire logic                      serial_data,
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [7:0]                reg_rdata,
  output logic                           cmd_valid,
  output logic      [7:0]                cmd_byte,
  output logic                           param_valid,
  output logic      [7:0]                param_byte,
  output logic                           pixel_valid,
  output logic      [17:0]               pixel_data
);

  localparam int PW = hpu_pkg::BUS_W + 9;
  localparam logic [PW-1:0] PIN_IDLE = {4'h0, 2'h3, {(PW-6){1'b0}}};
  function automatic logic [5:0] hpu_rep5(input logic [4:0] x);
    hpu_rep5 = {x, x[4]};
  endfunction : hpu_rep5

  function automatic logic [4:0] hpu_to5(input logic [3:0] x);
    hpu_to5 = {x, x[3]};
  endfunction : hpu_to5

  // Single-transfer 4-4-4 and 5-6-5 layouts shared by the wide buses
  function automatic logic [17:0] hpu_single(input logic [15:0] w,
                                             input hpu_pkg::hpu_depth_t d);
    if (d == hpu_pkg::HPU_D12)
      hpu_single = {2'h0, w[11:8], 2'h0, w[7:4], 2'h0, w[3:0]};
    else
      hpu_single = {1'b0, w[15:11], w[10:5], 1'b0, w[4:0]};
  endfunction : hpu_single

  // Pin synchronisers; everything reads the second stage or later
  logic [PW-1:0] pin_async;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic [PW-1:0] pin_prev;

  assign pin_async = {bus_select_pin_hi, bus_select_pin_mid,
                      bus_select_pin_lo, four_wire_sel, chip_select_n,
                      write_strobe_n, data_command_flag, serial_clock,
                      serial_data, bus_data};

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE; // Idle select and strobe: no false edge
    end else begin
      pin_meta <= pin_async;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic [2:0]  sel_code;
  logic        four_wire;
  logic        cs_n;
  logic        wr_n;
  logic        dc_pin;
  logic        scl;
  logic        sda;
  logic [17:0] dbus;
  logic        ser_mode;
  logic        scl_rise;
  logic        wr_rise;

  assign sel_code  = pin_sync[PW-1:PW-3];
  assign four_wire = pin_sync[PW-4];
  assign cs_n      = pin_sync[PW-5];
  assign wr_n      = pin_sync[PW-6];
  assign dc_pin    = pin_sync[PW-7];
  assign scl       = pin_sync[PW-8];
  assign sda       = pin_sync[PW-9];
  assign dbus      = pin_sync[17:0];
  assign ser_mode  = ~sel_code[2];
  assign scl_rise  = scl & ~pin_prev[PW-8];
  assign wr_rise   = wr_n & ~pin_prev[PW-6];

  // Serial receiver: chip select high aborts a partial byte
  logic [3:0] ser_cnt_reg;
  logic [7:0] ser_shift_reg;
  logic       ser_dc_reg;
  logic [3:0] ser_last;
  logic       ser_done;

  assign ser_last = four_wire ? hpu_pkg::SER_BITS_4LINE - 4'h1
                              : hpu_pkg::SER_BITS_3LINE - 4'h1;
  assign ser_done = ser_mode & ~cs_n & scl_rise & (ser_cnt_reg == ser_last);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ser_cnt_reg   <= 4'h0;
      ser_shift_reg <= 8'h00;
      ser_dc_reg    <= 1'b0;
    end else if (cs_n || !ser_mode) begin
      ser_cnt_reg <= 4'h0;
    end else if (scl_rise) begin
      if (!four_wire && ser_cnt_reg == 4'h0)
        ser_dc_reg <= sda;
      else
        ser_shift_reg <= {ser_shift_reg[6:0], sda};
      if (four_wire && ser_cnt_reg == 4'h7)
        ser_dc_reg <= dc_pin;
      ser_cnt_reg <= (ser_cnt_reg == ser_last) ? 4'h0 : ser_cnt_reg + 4'h1;
    end
  end

  // One transfer from either link, aligned to the parallel bus
  logic        in_valid;
  logic [17:0] in_word;
  logic        in_dc;
  hpu_pkg::hpu_bus_t bus_kind;

  assign in_valid = ser_done | (~ser_mode & ~cs_n & wr_rise);
  assign in_word  = ser_mode ? {10'h000, ser_shift_reg[6:0], sda} : dbus;
  assign in_dc    = (ser_mode && four_wire) ? dc_pin :
                    ser_mode ? ser_dc_reg : dc_pin;

  always_comb begin
    case (sel_code)
      hpu_pkg::IF_PAR16: bus_kind = hpu_pkg::HPU_BK16;
      hpu_pkg::IF_PAR9:  bus_kind = hpu_pkg::HPU_BK9;
      hpu_pkg::IF_PAR18: bus_kind = hpu_pkg::HPU_BK18;
      default:           bus_kind = hpu_pkg::HPU_BK8;
    endcase
  end

  // Command tracking
  hpu_pkg::hpu_depth_t depth_reg;
  logic fmt_pend_reg;
  logic ram_wr_reg;
  logic is_cmd;
  logic is_pix;

  assign is_cmd = in_valid & ~in_dc;
  assign is_pix = in_valid & in_dc & ~fmt_pend_reg & ram_wr_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      depth_reg    <= hpu_pkg::DEPTH_RESET;
      fmt_pend_reg <= 1'b0;
      ram_wr_reg   <= 1'b0;
    end else if (is_cmd) begin
      fmt_pend_reg <= (in_word[7:0] == hpu_pkg::PIXEL_FORMAT_COMMAND);
      ram_wr_reg   <= (in_word[7:0] == hpu_pkg::RAM_WRITE_COMMAND);
    end else if (in_valid && fmt_pend_reg) begin
      fmt_pend_reg <= 1'b0;
      case (in_word[2:0])
        hpu_pkg::FMT_12BPP: depth_reg <= hpu_pkg::HPU_D12;
        hpu_pkg::FMT_16BPP: depth_reg <= hpu_pkg::HPU_D16;
        hpu_pkg::FMT_18BPP: depth_reg <= hpu_pkg::HPU_D18;
        default:            depth_reg <= depth_reg;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_valid   <= 1'b0;
      cmd_byte    <= 8'h00;
      param_valid <= 1'b0;
      param_byte  <= 8'h00;
    end else begin
      cmd_valid   <= is_cmd;
      param_valid <= in_valid & in_dc & ~fmt_pend_reg & ~ram_wr_reg;
      if (is_cmd)
        cmd_byte <= in_word[7:0];
      if (in_valid && in_dc)
        param_byte <= in_word[7:0];
    end
  end

  // Unpacking: which transfer completes a pixel and where bits sit
  logic [1:0]  phase_reg;
  logic [15:0] stash_reg;
  logic [15:0] stash_next;
  logic        last;
  logic        emit;
  logic [5:0]  r_raw;
  logic [5:0]  g_raw;
  logic [5:0]  b_raw;
  logic [17:0] single;
  hpu_pkg::hpu_depth_t eff_depth;

  assign single    = hpu_single(in_word[15:0], depth_reg);
  assign eff_depth = (bus_kind == hpu_pkg::HPU_BK9) ? hpu_pkg::HPU_D18
                                                    : depth_reg;

  // Bits not named below are never read, so any level is accepted
  always_comb begin
    last       = 1'b1;
    emit       = 1'b1;
    stash_next = stash_reg;
    {r_raw, g_raw, b_raw} = single;
    case (bus_kind)
      hpu_pkg::HPU_BK8: begin
        stash_next = {stash_reg[7:0], in_word[7:0]};
        case (depth_reg)
          hpu_pkg::HPU_D12: begin
            last = (phase_reg == 2'h2);
            emit = (phase_reg != 2'h0);
            if (phase_reg == 2'h1)
              {r_raw, g_raw, b_raw} = {2'h0, stash_reg[7:4], 2'h0,
                                       stash_reg[3:0], 2'h0, in_word[7:4]};
            else
              {r_raw, g_raw, b_raw} = {2'h0, stash_reg[3:0], 2'h0,
                                       in_word[7:4], 2'h0, in_word[3:0]};
          end
          hpu_pkg::HPU_D16: begin
            last = (phase_reg == 2'h1);
            emit = last;
            {r_raw, g_raw, b_raw} = {1'b0, stash_reg[7:3], stash_reg[2:0],
                                     in_word[7:5], 1'b0, in_word[4:0]};
          end
          default: begin
            last = (phase_reg == 2'h2);
            emit = last;
            {r_raw, g_raw, b_raw} = {stash_reg[15:10], stash_reg[7:2],
                                     in_word[7:2]};
          end
        endcase
      end
      hpu_pkg::HPU_BK9: begin
        stash_next = {7'h00, in_word[8:0]};
        last = (phase_reg == 2'h1);
        emit = last;
        {r_raw, g_raw, b_raw} = {stash_reg[8:3], stash_reg[2:0],
                                 in_word[8:6], in_word[5:0]};
      end
      hpu_pkg::HPU_BK16: begin
        if (depth_reg == hpu_pkg::HPU_D18) begin
          stash_next = (phase_reg == 2'h0) ? in_word[15:0]
                                           : {10'h000, in_word[7:2]};
          last = (phase_reg == 2'h2);
          emit = (phase_reg != 2'h0);
          if (phase_reg == 2'h1)
            {r_raw, g_raw, b_raw} = {stash_reg[15:10], stash_reg[7:2],
                                     in_word[15:10]};
          else
            {r_raw, g_raw, b_raw} = {stash_reg[5:0], in_word[15:10],
                                     in_word[7:2]};
        end // use the single-transfer default
      end
      default: begin
        if (depth_reg == hpu_pkg::HPU_D18)
          {r_raw, g_raw, b_raw} = in_word;
      end
    endcase
  end

  // Widening to 6-6-6, through the table when software enables it
  logic [5:0] lut_mem [0:hpu_pkg::LUT_ENTRIES-1];
  logic       lut_en_reg;
  logic [4:0] r5;
  logic [4:0] b5;
  logic [5:0] g6;
  logic [17:0] pix666;

  always_comb begin
    r5 = r_raw[4:0];
    b5 = b_raw[4:0];
    g6 = g_raw;
    if (eff_depth == hpu_pkg::HPU_D12) begin
      r5 = hpu_to5(r_raw[3:0]);
      b5 = hpu_to5(b_raw[3:0]);
      g6 = {g_raw[3:0], g_raw[3:2]};
    end
    if (eff_depth == hpu_pkg::HPU_D18)
      pix666 = {r_raw, g_raw, b_raw};
    else if (lut_en_reg)
      pix666 = {lut_mem[{2'h0, r5}],
                lut_mem[{1'b0, g6} + hpu_pkg::LUT_GREEN_BASE],
                lut_mem[{2'h0, b5} + hpu_pkg::LUT_BLUE_BASE]};
    else
      pix666 = {hpu_rep5(r5), g6, hpu_rep5(b5)};
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= 2'h0;
      stash_reg <= 16'h0000;
    end else if (is_cmd || (in_valid && fmt_pend_reg)) begin
      phase_reg <= 2'h0;
      stash_reg <= 16'h0000;
    end else if (is_pix) begin
      phase_reg <= last ? 2'h0 : phase_reg + 2'h1;
      stash_reg <= stash_next;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pixel_valid <= 1'b0;
      pixel_data  <= 18'h00000;
    end else begin
      pixel_valid <= is_pix & emit;
      if (is_pix && emit)
        pixel_data <= pix666;
    end
  end

  // Register port; table holds no reset, so it starts disabled
  always_ff @(posedge clk) begin
    if (reg_write && reg_addr[hpu_pkg::REG_LUT_SEL_BIT])
      lut_mem[reg_addr[6:0]] <= reg_wdata[5:0];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      lut_en_reg <= hpu_pkg::CTRL_LUT_EN_RESET;
    else if (reg_write && reg_addr == hpu_pkg::REG_CTRL)
      lut_en_reg <= reg_wdata[hpu_pkg::CTRL_LUT_EN_BIT];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (!reg_read) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr[hpu_pkg::REG_LUT_SEL_BIT]) begin
      reg_rdata <= {2'h0, lut_mem[reg_addr[6:0]]};
    end else if (reg_addr == hpu_pkg::REG_CTRL) begin
      reg_rdata <= {7'h00, lut_en_reg};
    end else if (reg_addr == hpu_pkg::REG_STATUS) begin
      reg_rdata <= {ser_mode, ram_wr_reg, fmt_pend_reg, sel_code, depth_reg};
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : hpu_unpacker

// >>> hpu_monitor.sv
`timescale 1ns/1ns
module hpu_monitor (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        bus_select_pin_hi,
  input wire logic        bus_select_pin_mid,
  input wire logic        bus_select_pin_lo,
  input wire logic        chip_select_n,
  input wire logic        data_command_flag,
  input wire logic [17:0] bus_data,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [7:0]  reg_rdata,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_byte,
  input wire logic        param_valid,
  input wire logic [7:0]  param_byte,
  input wire logic        pixel_valid,
  input wire logic [17:0] pixel_data
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // Parallel results land three clocks after the strobe edge
  AST_CMD_FLAG: assert property (cmd_valid && bus_select_pin_hi
    |-> !$past(data_command_flag, 3)) else $error("command without low flag");
  AST_CMD_BYTE: assert property (cmd_valid && bus_select_pin_hi
    |-> cmd_byte == 8'($past(bus_data, 3))) else $error("command byte wrong");
  AST_PAR_DATA: assert property (param_valid && bus_select_pin_hi
    |-> $past(data_command_flag, 3) && param_byte == 8'($past(bus_data, 3)))
    else $error("parameter byte wrong");
  AST_PIX_SRC: assert property (pixel_valid && bus_select_pin_hi
    |-> $past(data_command_flag, 3) && !$past(chip_select_n, 3))
    else $error("pixel without data transfer");
  AST_ONE_KIND: assert property (cmd_valid
    |-> !pixel_valid && !param_valid) else $error("command and data at once");
  AST_PIX_HOLD: assert property (!pixel_valid
    |-> $stable(pixel_data)) else $error("pixel changed without write");
  AST_PIX_GAP: assert property (pixel_valid
    |=> !pixel_valid [*3]) else $error("pixel write too soon");
  AST_STAT_SEL: assert property ($past(reg_read)
    && $past(reg_addr) == 8'h01
    |-> reg_rdata[4:2] == {$past(bus_select_pin_hi, 3),
    $past(bus_select_pin_mid, 3), $past(bus_select_pin_lo, 3)})
    else $error("status select code wrong");
endmodule : hpu_monitor

bind hpu_unpacker hpu_monitor i_mon (.clk, .resetn, .bus_select_pin_hi,
  .bus_select_pin_mid, .bus_select_pin_lo, .chip_select_n,
  .data_command_flag, .bus_data, .reg_addr, .reg_read, .reg_rdata,
  .cmd_valid, .cmd_byte, .param_valid, .param_byte, .pixel_valid,
  .pixel_data);

// >>> hpu_host_model.sv
`timescale 1ns/1ns
module hpu_host_model (
  input  wire logic        clk,
  output logic             chip_select_n,
  output logic             write_strobe_n,
  output logic             data_command_flag,
  output logic [17:0]      bus_data,
  output logic             serial_clock,
  output logic             serial_data
);
  initial begin
    chip_select_n = 1'b1;
    write_strobe_n = 1'b1;
    data_command_flag = 1'b1;
    bus_data = 18'h2aaaa;
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end

  // Bus inverted after hold so a late sample cannot pass
  task automatic par_xfer(logic c, logic [17:0] d, int g);
    @(posedge clk);
    chip_select_n <= 1'b0;
    data_command_flag <= c;
    bus_data <= d;
    write_strobe_n <= 1'b0;
    repeat (3) @(posedge clk);
    write_strobe_n <= 1'b1;
    repeat (4) @(posedge clk);
    bus_data <= ~d;
    chip_select_n <= g != 0;
    repeat (g) @(posedge clk);
  endtask : par_xfer

  // Link clock stands low between bytes; a gap pauses chip select
  task automatic ser_byte(logic four, logic c, logic [7:0] d, logic g);
    logic [8:0] s;
    s = four ? {d, 1'b0} : {c, d};
    @(posedge clk);
    chip_select_n <= 1'b0;
    data_command_flag <= c;
    for (int i = 8; i >= (four ? 1 : 0); i--) begin
      serial_data <= s[i];
      repeat (4) @(posedge clk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge clk);
      serial_clock <= 1'b0;
    end
    serial_data <= ~s[four ? 1 : 0];
    repeat (10) @(posedge clk);
    chip_select_n <= g;
    repeat (10) @(posedge clk);
  endtask : ser_byte
endmodule : hpu_host_model

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic        clk, resetn, four_wire_sel, reg_write, reg_read;
  logic        bus_select_pin_hi, bus_select_pin_mid, bus_select_pin_lo;
  logic        chip_select_n, write_strobe_n, data_command_flag;
  logic        serial_clock, serial_data, ramwr, pend, lut_en;
  logic        cmd_valid, param_valid, pixel_valid;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, cmd_byte, param_byte;
  logic [17:0] bus_data, pixel_data;
  logic [19:0] exp_q[$];
  logic [63:0] acc;
  logic [5:0]  lut[128];
  logic [7:0]  fmt[3] = '{8'h03, 8'h05, 8'h06};
  int          bw[4] = '{8, 16, 9, 18};
  int          num_errors, total_checks, nb, dep, ef, bus;
  int          seed = 32'hf03ff948;

  always #5 clk = ~clk;

  hpu_unpacker i_dut (.clk, .resetn, .bus_select_pin_hi,
    .bus_select_pin_mid, .bus_select_pin_lo, .four_wire_sel,
    .chip_select_n, .write_strobe_n, .data_command_flag, .bus_data,
    .serial_clock, .serial_data, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .cmd_valid, .cmd_byte, .param_valid,
    .param_byte, .pixel_valid, .pixel_data);

  hpu_host_model i_host (.clk, .chip_select_n, .write_strobe_n,
    .data_command_flag, .bus_data, .serial_clock, .serial_data);

  task automatic check(string n, logic [19:0] e, logic [19:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic end_sim();
    check("leftover", 20'h0, 20'(exp_q.size()));
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  function automatic logic [7:0] stat();
    return {!bus_select_pin_hi, ramwr, pend, bus_select_pin_hi,
            bus_select_pin_mid, bus_select_pin_lo, 2'(dep)};
  endfunction : stat

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    check("register", {12'h0, e}, {12'h0, reg_rdata});
  endtask : reg_rd

  task automatic pix(logic [17:0] p);
    logic [4:0] r, b;
    logic [5:0] g;
    r = ef ? p[15:11] : {p[11:8], p[11]};
    g = ef ? p[10:5] : {p[7:4], p[7:6]};
    b = ef ? p[4:0] : {p[3:0], p[3]};
    if (ef == 2)
      exp_q.push_back({2'd2, p});
    else if (lut_en)
      exp_q.push_back({2'd2, lut[r], lut[32 + g], lut[96 + b]});
    else
      exp_q.push_back({2'd2, r, r[4], g, b, b[4]});
  endtask : pix

  // Transfers feed one bit stream; a pixel leaves once its bits are in
  task automatic put(logic [17:0] v, int w);
    acc = (acc << w) | (64'(v) & ((64'h1 << w) - 1));
    nb += w;
    if (nb >= (ef == 2 ? 18 : 12 + 4 * ef)) begin
      nb -= ef == 2 ? 18 : 12 + 4 * ef;
      pix(18'(acc >> nb));
    end
  endtask : put

  task automatic model(logic c, logic [17:0] d);
    ef = bus == 9 ? 2 : dep;
    if (!c) begin
      exp_q.push_back({12'h000, d[7:0]});
      nb = 0;
      ramwr = d[7:0] == 8'h2c;
      pend = d[7:0] == 8'h3a;
    end else if (pend) begin
      pend = 1'b0;
      nb = 0;
      if (d[2:0] == 3'h3) dep = 0;
      if (d[2:0] == 3'h5) dep = 1;
      if (d[2:0] == 3'h6) dep = 2;
    end else if (!ramwr)
      exp_q.push_back({12'h400, d[7:0]});
    else if (bus == 8)
      put(ef == 2 ? d >> 2 : d, ef == 2 ? 6 : 8);
    else if (bus == 9)
      put(d, 9);
    else if (ef == 2 && bus == 16) begin
      put(d >> 10, 6);
      put(d >> 2, 6);
    end else
      put(d, ef == 2 ? 18 : 12 + 4 * ef);
  endtask : model

  task automatic send(logic c, logic [17:0] d);
    int g;
    g = {$random(seed)} % 3;
    model(c, d);
    if (bus_select_pin_hi)
      i_host.par_xfer(c, d, g);
    else
      i_host.ser_byte(four_wire_sel, c, d[7:0], g[0]);
  endtask : send

  // Bad format code must leave depth alone; command drops a partial pixel
  task automatic run(logic [7:0] f);
    send(1'b0, 18'h0003a);
    send(1'b1, {10'h3ff, f});
    send(1'b0, 18'h0003a);
    send(1'b1, 18'h00077);
    send(1'b0, 18'h0002c);
    if (bus != 9)
      reg_rd(8'h01, stat());
    repeat (7) send(1'b1, 18'($random(seed)));
    send(1'b0, 18'h0002c);
    repeat (6) send(1'b1, 18'($random(seed)));
  endtask : run

  always @(negedge clk) begin
    if (resetn && (cmd_valid || param_valid || pixel_valid))
      check("output", exp_q.size() > 0 ? exp_q.pop_front() : 20'hxxxxx,
            pixel_valid ? {2'd2, pixel_data} :
            param_valid ? {12'h400, param_byte} : {12'h000, cmd_byte});
  end

  initial begin
    #500000;
    check("timeout", 20'h0, 20'h1);
    end_sim();
  end

  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    {bus_select_pin_hi, bus_select_pin_mid, bus_select_pin_lo} = 3'b100;
    {four_wire_sel, reg_write, reg_read, ramwr, pend, lut_en} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {dep, nb, bus, acc} = {32'd2, 32'd0, 32'd8, 64'h0};
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    reg_rd(8'h00, 8'h00);
    reg_rd(8'h01, stat());
    reg_wr(8'h05, 8'hff);
    reg_rd(8'h05, 8'h00);
    send(1'b1, 18'h3ff5a);
    for (int i = 0; i < 4; i++) begin
      {bus_select_pin_hi, bus_select_pin_mid, bus_select_pin_lo} <= 3'(4 + i);
      bus = bw[i];
      repeat (6) @(posedge clk);
      foreach (fmt[f]) run(fmt[f]);
    end
    for (int i = 0; i < 128; i++) begin
      lut[i] = 6'($random(seed));
      reg_wr(8'(128 + i), {2'b00, lut[i]});
    end
    reg_rd(8'h85, {2'b00, lut[5]});
    reg_wr(8'h00, 8'h01);
    lut_en = 1'b1;
    for (int s = 0; s < 2; s++) begin
      {bus_select_pin_hi, bus_select_pin_mid, bus_select_pin_lo} <= 3'b000;
      four_wire_sel <= s[0];
      bus = 8;
      repeat (6) @(posedge clk);
      foreach (fmt[f]) run(fmt[f]);
    end
    repeat (30) @(posedge clk);
    end_sim();
  end
endmodule : tb_top
